// [dma_channel_control_pkg.sv]
// Purpose: Shared constants and types for the DMA channel control block.
// Assumes: AXI4-Lite slave with 8-bit byte addresses and 32-bit data.
// Notes: Each register takes one aligned word, data in the low bits.
`default_nettype none
package dma_channel_control_pkg;
	// ****************************************
	// Sizes and register map
	// ****************************************
	localparam int CHANNELS = 3;
	localparam logic [7:0] GLOBAL_OFFSET = 8'h00;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h04;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h08;
	localparam logic [7:0] CHANNEL_BASE = 8'h10;
	localparam logic [7:0] CHANNEL_STRIDE = 8'h10;
	localparam logic [7:0] CTL_SUB = 8'h00;
	localparam logic [7:0] SRC_SUB = 8'h04;
	localparam logic [7:0] SIZE_SUB = 8'h08;
	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int NMI_ABORT_BIT = 0;
	localparam int ROTATE_BIT = 1;
	localparam int FETCH_ALIGNED_BIT = 2;
	localparam int SW_REQ_BIT = 0;
	localparam int ABORTED_BIT = 1;
	localparam int IRQ_ENABLE_BIT = 2;
	localparam int IRQ_FLAG_BIT = 3;
	localparam int ENABLE_BIT = 4;
	localparam int LEVEL_BIT = 5;
	localparam int SRC_BYTE_BIT = 6;
	localparam int DST_BYTE_BIT = 7;
	localparam int SRC_STEP_LSB = 8;
	localparam int ABORT_STATUS_LSB = 3;
	localparam logic [15:0] CTL_STORED_MASK = 16'h7FFE;
	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [2:0] GLOBAL_RESET = 3'h0;
	localparam logic [5:0] MASK_RESET = 6'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		STEP_HOLD = 2'b00,
		STEP_HOLD_ALT = 2'b01,
		STEP_DOWN = 2'b10,
		STEP_UP = 2'b11
	} step_mode_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT_FETCH = 2'b01,
		ST_MOVE = 2'b10
	} state_type;
	typedef struct packed {
		logic valid;
		logic [1:0] channel;
		logic [15:0] src_addr;
		logic src_byte;
		logic dst_byte;
	} xfer_req_type;
endpackage
`default_nettype wire

// [dma_channel_control.sv]
// Purpose: Three-channel DMA control: triggers, priority, NMI abort, regs.
// Assumes: All inputs synchronous to aclk; memory side answers xfer_done.
// Notes: One transfer at a time; the data mover itself lives outside.
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_control
	import dma_channel_control_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [2:0] trigger,
	input wire logic fetch_strobe,
	input wire logic nmi,
	input wire logic xfer_done,
	output var xfer_req_type xfer_req,
	output logic irq
);
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [CHANNELS-1:0] chan_hit(input logic [7:0] a,
		input logic [7:0] sub);
		chan_hit = '0;
		for (int i = 0; i < CHANNELS; i++) begin
			if (a == CHANNEL_BASE + 8'(i) * CHANNEL_STRIDE + sub) begin
				chan_hit[i] = 1'b1;
			end
		end
	endfunction

	function automatic logic [1:0] idx_of(input logic [2:0] oh);
		idx_of = oh[2] ? 2'h2 : (oh[1] ? 2'h1 : 2'h0);
	endfunction

	function automatic logic [1:0] next_ch(input logic [1:0] c);
		next_ch = (c == 2'h2) ? 2'h0 : c + 2'h1;
	endfunction

	// Priority walk from first; found flag in bit 2
	function automatic logic [2:0] pick(input logic [2:0] req,
		input logic [1:0] first);
		logic [1:0] idx;
		pick = 3'h0;
		idx = first;
		for (int k = 0; k < CHANNELS; k++) begin
			if (req[idx] && !pick[2]) begin
				pick = {1'b1, idx};
			end
			idx = next_ch(idx);
		end
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// ****************************************
	// State
	// ****************************************
	logic [2:0] global_ctl;
	logic [5:0] irq_mask;
	logic [15:0] ctl [CHANNELS];
	logic [15:0] src_addr_reg [CHANNELS];
	logic [15:0] size_reg [CHANNELS];
	logic [15:0] work_src [CHANNELS];
	logic [15:0] count [CHANNELS];
	logic [15:0] next_ctl [CHANNELS];
	logic [15:0] next_work_src [CHANNELS];
	logic [15:0] next_count [CHANNELS];
	logic [CHANNELS-1:0] pend, next_pend, trig_prev, done, abort;
	logic [CHANNELS-1:0] flags, aborted, irq_en;
	logic [CHANNELS-1:0] wr_ctl, wr_src, wr_size, rd_ctl, rd_src, rd_size;
	logic [5:0] irq_status;
	state_type state, next_state;
	logic [1:0] active_ch, rr_first;
	logic nmi_pending, nmi_hit, halting, next_nmi;
	logic [2:0] grant;
	logic aw_held, w_held, do_write, wr_global, wr_status, wr_mask, wr_known;
	logic [7:0] aw_addr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [31:0] rd_value;
	logic rd_known;
	xfer_req_type next_xfer;

	// ****************************************
	// Register decode
	// ****************************************
	assign do_write = aw_held && w_held && !bvalid;
	assign wr_global = do_write && aw_addr_q == GLOBAL_OFFSET;
	assign wr_status = do_write && aw_addr_q == IRQ_STATUS_OFFSET;
	assign wr_mask = do_write && aw_addr_q == IRQ_MASK_OFFSET;
	assign wr_ctl = do_write ? chan_hit(aw_addr_q, CTL_SUB) : '0;
	assign wr_src = do_write ? chan_hit(aw_addr_q, SRC_SUB) : '0;
	assign wr_size = do_write ? chan_hit(aw_addr_q, SIZE_SUB) : '0;
	assign wr_known = wr_global || wr_status || wr_mask || (|wr_ctl)
		|| (|wr_src) || (|wr_size);
	assign rd_ctl = chan_hit(araddr, CTL_SUB);
	assign rd_src = chan_hit(araddr, SRC_SUB);
	assign rd_size = chan_hit(araddr, SIZE_SUB);
	assign irq_status = {aborted, flags};

	always_comb begin
		rd_value = '0;
		rd_known = 1'b1;
		if (araddr == GLOBAL_OFFSET) begin
			rd_value = {29'h0, global_ctl};
		end else if (araddr == IRQ_STATUS_OFFSET) begin
			rd_value = {26'h0, irq_status};
		end else if (araddr == IRQ_MASK_OFFSET) begin
			rd_value = {26'h0, irq_mask};
		end else if (|rd_ctl) begin
			rd_value = {16'h0, ctl[idx_of(rd_ctl)]};
		end else if (|rd_src) begin
			rd_value = {16'h0, src_addr_reg[idx_of(rd_src)]};
		end else if (|rd_size) begin
			rd_value = {16'h0, size_reg[idx_of(rd_size)]};
		end else begin
			rd_known = 1'b0;
		end
	end

	// ****************************************
	// Channels
	// ****************************************
	for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
		logic hw_trig, sw_req, block_end, clr_flag, clr_abort;
		logic [15:0] step, wr_val;
		assign flags[i] = ctl[i][IRQ_FLAG_BIT];
		assign aborted[i] = ctl[i][ABORTED_BIT];
		assign irq_en[i] = ctl[i][IRQ_ENABLE_BIT];
		assign wr_val = merge16(ctl[i], wdata_q, wstrb_q);
		assign sw_req = wr_ctl[i] && wstrb_q[0] && wdata_q[SW_REQ_BIT];
		assign hw_trig = ctl[i][LEVEL_BIT] ? trigger[i]
			: trigger[i] && !trig_prev[i];
		assign done[i] = state == ST_MOVE && xfer_done && active_ch == 2'(i);
		assign abort[i] = halting && active_ch == 2'(i);
		assign block_end = done[i] && count[i] == 16'h0001;
		assign clr_flag = wr_status && wstrb_q[0] && wdata_q[i];
		assign clr_abort = wr_status && wstrb_q[0]
			&& wdata_q[ABORT_STATUS_LSB + i];
		// Hardware sets come last so an event beats a same-cycle clear
		always_comb begin
			next_ctl[i] = wr_ctl[i] ? (wr_val & CTL_STORED_MASK) : ctl[i];
			if (clr_flag) begin
				next_ctl[i][IRQ_FLAG_BIT] = 1'b0;
			end
			if (clr_abort) begin
				next_ctl[i][ABORTED_BIT] = 1'b0;
			end
			if (block_end) begin
				next_ctl[i][IRQ_FLAG_BIT] = 1'b1;
			end
			if (abort[i]) begin
				next_ctl[i][ENABLE_BIT] = 1'b0;
				next_ctl[i][ABORTED_BIT] = 1'b1;
			end
		end
		assign next_pend[i] = next_ctl[i][ENABLE_BIT] && size_reg[i] != 16'h0
			&& !abort[i] && (hw_trig || sw_req || (pend[i] && !done[i]));
		assign next_count[i] = wr_size[i] ? merge16(count[i], wdata_q, wstrb_q)
			: block_end ? size_reg[i]
			: done[i] ? count[i] - 16'h0001 : count[i];
		assign step = ctl[i][SRC_BYTE_BIT] ? 16'h0001 : 16'h0002;
		always_comb begin
			next_work_src[i] = work_src[i];
			if (wr_src[i]) begin
				next_work_src[i] = merge16(src_addr_reg[i], wdata_q, wstrb_q);
			end else if (block_end) begin
				next_work_src[i] = src_addr_reg[i];
			end else if (done[i]) begin
				case (step_mode_type'(ctl[i][SRC_STEP_LSB +: 2]))
					STEP_UP: next_work_src[i] = work_src[i] + step;
					STEP_DOWN: next_work_src[i] = work_src[i] - step;
					default: next_work_src[i] = work_src[i];
				endcase
			end
		end
	end

	// ****************************************
	// Arbitration and sequencing
	// ****************************************
	// Fixed order is the rotating walk pinned to channel 0
	assign grant = pick(pend, global_ctl[ROTATE_BIT] ? rr_first : 2'h0);
	assign nmi_hit = nmi_pending || (nmi && global_ctl[NMI_ABORT_BIT]);
	assign halting = nmi_hit && ((state == ST_MOVE && xfer_done)
		|| state == ST_WAIT_FETCH);
	assign next_nmi = state != ST_IDLE && !halting && nmi_hit;

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (grant[2]) begin
					next_state = global_ctl[FETCH_ALIGNED_BIT] ? ST_WAIT_FETCH
						: ST_MOVE;
				end
			end
			ST_WAIT_FETCH: begin
				if (halting) begin
					next_state = ST_IDLE;
				end else if (fetch_strobe) begin
					next_state = ST_MOVE;
				end
			end
			ST_MOVE: begin
				if (xfer_done) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_comb begin
		next_xfer = xfer_req;
		next_xfer.valid = next_state == ST_MOVE;
		if (state == ST_IDLE && grant[2]) begin
			next_xfer.channel = grant[1:0];
			next_xfer.src_addr = work_src[grant[1:0]];
			next_xfer.src_byte = ctl[grant[1:0]][SRC_BYTE_BIT];
			next_xfer.dst_byte = ctl[grant[1:0]][DST_BYTE_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			active_ch <= 2'h0;
			rr_first <= 2'h0;
			nmi_pending <= 1'b0;
			xfer_req <= '0;
			irq <= 1'b0;
			pend <= 3'h0;
			trig_prev <= 3'h0;
		end else begin
			state <= next_state;
			if (state == ST_IDLE && grant[2]) begin
				active_ch <= grant[1:0];
			end
			if (|done) begin
				rr_first <= next_ch(active_ch);
			end
			nmi_pending <= next_nmi;
			xfer_req <= next_xfer;
			irq <= |(irq_status & irq_mask & {3'h7, irq_en});
			pend <= next_pend;
			trig_prev <= trigger;
		end
	end

	always_ff @(posedge aclk) begin
		for (int i = 0; i < CHANNELS; i++) begin
			if (!aresetn) begin
				ctl[i] <= CTL_RESET;
				src_addr_reg[i] <= WORD_RESET;
				size_reg[i] <= WORD_RESET;
				work_src[i] <= WORD_RESET;
				count[i] <= WORD_RESET;
			end else begin
				ctl[i] <= next_ctl[i];
				if (wr_src[i]) begin
					src_addr_reg[i] <= merge16(src_addr_reg[i], wdata_q, wstrb_q);
				end
				if (wr_size[i]) begin
					size_reg[i] <= merge16(size_reg[i], wdata_q, wstrb_q);
				end
				work_src[i] <= next_work_src[i];
				count[i] <= next_count[i];
			end
		end
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			global_ctl <= GLOBAL_RESET;
			irq_mask <= MASK_RESET;
		end else begin
			if (wr_global && wstrb_q[0]) begin
				global_ctl <= wdata_q[2:0];
			end
			if (wr_mask && wstrb_q[0]) begin
				irq_mask <= wdata_q[5:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{aw_held, w_held, awready, wready, bvalid} <= 5'h00;
			bresp <= RESP_OKAY;
			aw_addr_q <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				awready <= 1'b0;
				aw_addr_q <= awaddr;
			end else if (!aw_held) begin
				awready <= 1'b1;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				wready <= 1'b0;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end else if (!w_held) begin
				wready <= 1'b1;
			end
			if (do_write) begin
				bvalid <= 1'b1;
				bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{arready, rvalid} <= 2'h0;
			rdata <= 32'h0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_value;
			rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence start_now_s;
		state == ST_IDLE && grant[2] && !global_ctl[FETCH_ALIGNED_BIT];
	endsequence
	sequence start_fetch_s;
		state == ST_IDLE && grant[2] && global_ctl[FETCH_ALIGNED_BIT];
	endsequence

	global_upper_zero_a: assert property (
		arvalid && arready && araddr == GLOBAL_OFFSET |=> rdata[31:3] == 29'h0)
		else $error("global control upper bits not zero");
	start_immediate_a: assert property (
		start_now_s |=> state == ST_MOVE && xfer_req.valid)
		else $error("transfer did not start at once");
	fetch_wait_a: assert property (
		start_fetch_s ##1 (!fetch_strobe && !nmi_hit) |=> !xfer_req.valid)
		else $error("transfer started before fetch");
	fixed_order_a: assert property (
		state == ST_IDLE && !global_ctl[ROTATE_BIT] && pend[0]
		|=> active_ch == 2'h0)
		else $error("channel zero not granted first");
	rotate_order_a: assert property (
		global_ctl[ROTATE_BIT] && |done |=> rr_first == next_ch($past(active_ch)))
		else $error("priority did not rotate");
	nmi_ignored_a: assert property (
		state == ST_MOVE && !global_ctl[NMI_ABORT_BIT] && !nmi_pending
		&& xfer_done |=> !aborted[$past(active_ch)] || $past(aborted[active_ch]))
		else $error("nmi acted while disabled");
	abort_halt_a: assert property (
		state == ST_MOVE && xfer_done && nmi_pending
		|=> aborted[$past(active_ch)] && !ctl[$past(active_ch)][ENABLE_BIT]
		&& state == ST_IDLE)
		else $error("nmi abort did not halt channel");

	for (genvar i = 0; i < CHANNELS; i++) begin : g_chk
		sw_req_clear_a: assert property (
			g_chan[i].sw_req && next_pend[i] |=> pend[i] && !ctl[i][SW_REQ_BIT])
			else $error("software request not taken or not cleared");
		edge_only_a: assert property (
			!ctl[i][LEVEL_BIT] && !pend[i] && trigger[i] && trig_prev[i]
			&& !g_chan[i].sw_req |=> !pend[i])
			else $error("edge trigger fired on a level");
		count_reload_a: assert property (
			g_chan[i].block_end && !wr_size[i] |=> count[i] == size_reg[i])
			else $error("count not reloaded");
		src_step_a: assert property (
			done[i] && !g_chan[i].block_end && !wr_src[i]
			&& ctl[i][SRC_STEP_LSB +: 2] == STEP_UP
			|=> work_src[i] == $past(work_src[i]) + $past(g_chan[i].step)
			&& $stable(src_addr_reg[i]))
			else $error("source copy stepped wrongly");
	end
endmodule // dma_channel_control
`default_nettype wire

// [mem_side_model.sv]
// Purpose: Memory side stand-in that finishes each requested move.
// Assumes: One move at a time, as the control block offers them.
// Notes: lag sets how many cycles a move takes before done.
`timescale 1ns/1ps
`default_nettype none
module mem_side_model
	import dma_channel_control_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire xfer_req_type xfer_req,
	input wire logic [3:0] lag,
	output logic xfer_done
);
	// ****************************************
	// Move completion
	// ****************************************
	logic [3:0] waited;
	// Done is one cycle only; a held done would finish two moves
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			waited <= 4'h0;
			xfer_done <= 1'h0;
		end else if (xfer_done || !xfer_req.valid) begin
			waited <= 4'h0;
			xfer_done <= 1'h0;
		end else if (waited >= lag) begin
			xfer_done <= 1'h1;
		end else begin
			waited <= waited + 4'h1;
		end
	end
endmodule // mem_side_model
`default_nettype wire

// [dma_channel_control_tb.sv]
// Purpose: Self-checking bench for the DMA channel control block.
// Assumes: The memory side model answers each move after lag cycles.
// Notes: Every finished move is logged in queues; each test after the register test checks their count or their contents.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_control_tb;
	import dma_channel_control_pkg::*;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, nmi;
	logic awready, wready, bvalid, arready, rvalid, fetch_strobe;
	logic xfer_done, irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd, src_exp, lf;
	logic [3:0] wstrb, lag;
	logic [1:0] bresp, rresp, rs;
	logic [2:0] trigger;
	logic [15:0] ctl;
	xfer_req_type xfer_req;
	int failures, n_checks, step, ch, n0;
	logic [1:0] gch[$];
	logic [15:0] gsrc[$];
	logic [1:0] gbyte[$];
	dma_channel_control i_dma_channel_control(.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .trigger(trigger),
		.fetch_strobe(fetch_strobe), .nmi(nmi), .xfer_done(xfer_done),
		.xfer_req(xfer_req), .irq(irq));
	mem_side_model i_mem_side_model(.aclk(aclk), .aresetn(aresetn),
		.xfer_req(xfer_req), .lag(lag), .xfer_done(xfer_done));
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] ca(input int n, input logic [7:0] sub);
		return CHANNEL_BASE + CHANNEL_STRIDE * 8'(n) + sub;
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wm(input int n);
		while (gch.size() < n) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		rs = bresp;
		bready <= 1'h0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		rd = rdata;
		rs = rresp;
		rready <= 1'h0;
	endtask
	task automatic wrap_up;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Log every finished move as the memory side model sees it
	always @(posedge aclk) begin
		if (aresetn && xfer_req.valid && xfer_done) begin
			gch.push_back(xfer_req.channel);
			gsrc.push_back(xfer_req.src_addr);
			gbyte.push_back({xfer_req.src_byte, xfer_req.dst_byte});
		end
	end
	initial begin
		aclk = 1'h0;
		forever #50 aclk = ~aclk;
	end
	// Whole run needs under a thousand cycles; this bounds every wait
	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		$display("watchdog expired");
		wrap_up();
	end
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, nmi, fetch_strobe} = '0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h00000000;
		wstrb = 4'hF;
		trigger = 3'h0;
		lag = 4'h0;
		aresetn = 1'h0;
		lf = 32'h00014607;
		failures = 0;
		n_checks = 0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		wr(GLOBAL_OFFSET, 32'hFFFFFFFF);
		chk("write resp", rs, RESP_OKAY);
		rdr(GLOBAL_OFFSET);
		chk("global", rd, 32'h00000007);
		wr(GLOBAL_OFFSET, 32'h00000000);
		rdr(8'hFC);
		chk("unmapped data", rd, 32'h00000000);
		chk("unmapped resp", rs, RESP_SLVERR);
		wr(8'hFC, 32'h0000FFFF);
		chk("unmapped write", rs, RESP_SLVERR);
		$display("test registers done");
		for (int k = 0; k < 2; k++) begin
			ch = k * 2;
			ctl = k ? 16'h0254 : 16'h0394;
			step = k ? -1 : 2;
			lf = lfsr(lf);
			src_exp = {16'h0000, lf[15:1], 1'h0};
			gch.delete();
			gsrc.delete();
			gbyte.delete();
			wr(ca(ch, SRC_SUB), src_exp);
			wr(ca(ch, SIZE_SUB), 32'h00000002);
			wr(IRQ_MASK_OFFSET, 32'h0000003F);
			wr(ca(ch, CTL_SUB), {16'h0000, ctl | 16'h0001});
			rdr(ca(ch, CTL_SUB));
			chk("request bit", rd[0], 1'h0);
			wm(1);
			wr(ca(ch, CTL_SUB), {16'h0000, ctl | 16'h0001});
			wm(2);
			cyc(10);
			chk("moves", gch.size(), 2);
			chk("irq set", irq, 1'h1);
			rdr(IRQ_STATUS_OFFSET);
			chk("status", rd, 32'h00000001 << ch);
			wr(IRQ_MASK_OFFSET, 32'h00000000);
			cyc(3);
			chk("irq masked", irq, 1'h0);
			wr(IRQ_MASK_OFFSET, 32'h0000003F);
			wr(IRQ_STATUS_OFFSET, 32'h00000001 << ch);
			cyc(3);
			chk("irq cleared", irq, 1'h0);
			wr(ca(ch, CTL_SUB), {16'h0000, ctl | 16'h0001});
			wm(3);
			for (int i = 0; i < 3; i++) begin
				chk("channel", gch[i], ch);
				chk("source", gsrc[i], 16'(src_exp + step * (i % 2)));
				chk("byte sizes", gbyte[i], k ? 2'h2 : 2'h1);
			end
			wr(ca(ch, CTL_SUB), 32'h00000000);
		end
		$display("test block and irq done");
		gch.delete();
		wr(ca(1, SIZE_SUB), 32'h00000010);
		wr(ca(1, CTL_SUB), 32'h00000010);
		trigger <= 3'h2;
		cyc(40);
		chk("edge moves", gch.size(), 1);
		trigger <= 3'h0;
		wr(ca(1, CTL_SUB), 32'h00000030);
		trigger <= 3'h2;
		cyc(40);
		chk("level moves", gch.size() > 2, 1);
		trigger <= 3'h0;
		$display("test trigger modes done");
		for (int c = 0; c < 3; c++) begin
			wr(ca(c, SIZE_SUB), 32'h00000010);
			wr(ca(c, CTL_SUB), 32'h00000030);
		end
		cyc(10);
		gch.delete();
		trigger <= 3'h7;
		wm(6);
		for (int i = 0; i < 6; i++) chk("fixed order", gch[i], 0);
		wr(GLOBAL_OFFSET, 32'h00000002);
		wm(gch.size() + 1);
		n0 = gch.size();
		wm(n0 + 7);
		for (int i = n0 + 1; i < n0 + 7; i++) begin
			chk("rotation", gch[i], (gch[i - 1] + 1) % 3);
		end
		trigger <= 3'h0;
		// Let held requests drain, or they would park waiting for a fetch
		cyc(20);
		wr(GLOBAL_OFFSET, 32'h00000004);
		$display("test priority done");
		cyc(10);
		gch.delete();
		wr(ca(0, CTL_SUB), 32'h00000011);
		cyc(20);
		chk("wait for fetch", xfer_req.valid, 1'h0);
		fetch_strobe <= 1'h1;
		@(posedge aclk);
		fetch_strobe <= 1'h0;
		cyc(12);
		chk("fetch move", gch.size(), 1);
		$display("test fetch aligned done");
		lag <= 4'h8;
		for (int k = 0; k < 2; k++) begin
			wr(GLOBAL_OFFSET, 32'(k));
			gch.delete();
			wr(ca(2, CTL_SUB), 32'h00000011);
			while (!xfer_req.valid) @(posedge aclk);
			nmi <= 1'h1;
			@(posedge aclk);
			nmi <= 1'h0;
			cyc(30);
			chk("nmi move", gch.size(), 1);
			rdr(ca(2, CTL_SUB));
			chk("enable, aborted", {rd[4], rd[1]}, k ? 2'h1 : 2'h2);
			rdr(IRQ_STATUS_OFFSET);
			chk("abort status", rd[5], k);
		end
		$display("test nmi abort done");
		wrap_up();
	end
endmodule // dma_channel_control_tb
`default_nettype wire
